// >>> hw/sss_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes both sides on the same clock.
`timescale 1ns/1ns
module sss_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// >>> hw/sss_pkg.sv
// Constants for the status-reporting and serial-link block.
// Assumes one 25 MHz clock domain.
package sss_pkg;
  localparam int SSS_FIFO_WIDTH = 9;
  localparam int SSS_FIFO_DEPTH = 16;

  // Select codes of the register access port
  localparam logic [3:0] SEL_STATUS_SUMMARY_BYTE = 4'h0;
  localparam logic [3:0] SEL_SERVICE_REQUEST_MASK = 4'h1;
  localparam logic [3:0] SEL_STANDARD_EVENT_FLAGS = 4'h2;
  localparam logic [3:0] SEL_STANDARD_EVENT_MASK = 4'h3;
  localparam logic [3:0] SEL_OPERATION_EVENT_LATCH = 4'h4;
  localparam logic [3:0] SEL_OPERATION_CONDITION_LIVE = 4'h5;
  localparam logic [3:0] SEL_OPERATION_EVENT_MASK = 4'h6;
  localparam logic [3:0] SEL_QUESTIONABLE_EVENT_LATCH = 4'h7;
  localparam logic [3:0] SEL_QUESTIONABLE_CONDITION_LIVE = 4'h8;
  localparam logic [3:0] SEL_QUESTIONABLE_EVENT_MASK = 4'h9;

  // Status summary byte bits
  localparam int STB_OPER = 7;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_QUES = 3;
  localparam int STB_QUEUE = 2;
  localparam int STB_RQS = 6;

  // Standard event flag bits
  localparam int ESR_PON = 7;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_OPC = 0;
  localparam logic [7:0] ESR_RESET = 8'h80;

  // Operation condition bits
  localparam int OPC_CAL = 0;
  localparam int OPC_SETTLE = 1;
  localparam int OPC_RANGE = 2;
  localparam int OPC_MEAS = 4;
  localparam int OPC_TEST = 8;
  localparam int OPC_PROG = 14;

  // Questionable condition bits
  localparam int QC_VOLT = 0;
  localparam int QC_TIME = 2;
  localparam int QC_TEMP = 3;
  localparam int QC_CAL = 7;
  localparam int QC_PRES = 8;
  localparam int QC_WARN = 14;

  localparam int EMUL_REMOTE_BIT = 2;

  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_CTRLC = 8'h03;
  localparam logic [7:0] CH_COLON = 8'h3a;

  localparam logic [15:0] MASK16_RESET = 16'h0000;
  localparam logic [7:0] MASK8_RESET = 8'h00;

  typedef enum logic [2:0]
  {
    TX_DATA = 3'b001,
    TX_CR = 3'b010,
    TX_LF = 3'b100
  } sss_tx_state_t;
endpackage

// >>> hw/sss_status_serial.sv
// Status reporting structure, parser-mode switch and serial link handling.
// Assumes a byte-wide receiver/transmitter and a command engine on ref_clk;
// condition inputs come from elsewhere and are synchronised here.
// Operation
// RL1 - Status bit 7: enabled operation events summary
// RL2 - Status bit 5: enabled standard events summary
// RL3 - Status bit 4: response ready to send
// RL4 - Status bit 3: enabled questionable events summary
// RL5 - Bit 2 error queue; bits 1,0 zero
// RL6 - Power-on flag set; bits 6,1 zero
// RL7 - Bit 5 set on syntax error
// RL8 - Bit 4 execution, bit 3 device errors
// RL9 - Bit 2 set: query with empty output
// RL10 - Bit 0 set on operation complete
// RL11 - Operation bits: calibrating, settling, fast sensor
// RL12 - Bit 4 one; 8 test; 14 program
// RL13 - Questionable bit 0 supply; bit 1 zero
// RL14 - Bit 2 clock unset, bit 3 oven
// RL15 - Bit 7 uncalibrated, bit 8 overrange; others zero
// RL16 - Bit 14 set when parameter ignored
// RL17 - Emulation: colon-led message goes standard parser
// RL18 - Emulation: remote flag set, relay outputs off
// RL19 - Language command switches parser mode
// RL20 - Accept CR or LF; send CR LF
// RL21 - XOFF pauses transmitter until XON
// RL22 - Control-C flushes buffers, disables addressing
// RL23 - Event read clears; condition read harmless
// RL24 - Event latches on condition rising edge
`timescale 1ns/1ns
module sss_status_serial
  import sss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic single_unit,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic cmd_end,
  output logic cmd_to_standard,
  output logic rx_flush,
  output logic addressing_on,
  input wire logic addressing_set,
  input wire logic resp_valid,
  input wire logic [7:0] resp_byte,
  input wire logic resp_last,
  output logic resp_ready,
  input wire logic lang_emulation,
  input wire logic lang_standard,
  output logic emulation_mode,
  output logic [7:0] emul_status_byte0,
  output logic [7:0] relay_strip_output,
  input wire logic ev_cmd_error,
  input wire logic ev_exec_error,
  input wire logic ev_device_error,
  input wire logic ev_query,
  input wire logic ev_opc,
  input wire logic ev_param_ignored,
  input wire logic err_queue_nonempty,
  input wire logic [9:0] cond_pins,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [3:0] acc_sel,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata,
  output logic acc_rvalid,
  output logic [7:0] status_summary_byte,
  output logic service_request
);
  logic [9:0] cond_meta_reg;
  logic [9:0] cond_sync_reg;
  logic [15:0] operation_condition_live;
  logic [15:0] questionable_condition_live;
  logic [15:0] oper_prev_reg;
  logic [15:0] ques_prev_reg;
  logic [15:0] operation_event_latch_reg;
  logic [15:0] questionable_event_latch_reg;
  logic [15:0] operation_event_mask_reg;
  logic [15:0] questionable_event_mask_reg;
  logic [7:0] standard_event_flags_reg;
  logic [7:0] standard_event_mask_reg;
  logic [7:0] service_request_mask_reg;
  logic [7:0] status_summary_byte_reg;
  logic [7:0] stb_next;
  logic service_request_reg;
  logic [15:0] acc_rdata_reg;
  logic acc_rvalid_reg;
  logic emulation_mode_reg;
  logic msg_start_reg;
  logic cmd_to_standard_reg;
  logic cmd_valid_reg;
  logic [7:0] cmd_byte_reg;
  logic cmd_end_reg;
  logic rx_flush_reg;
  logic addressing_on_reg;
  logic tx_paused_reg;
  logic tx_valid_reg;
  logic [7:0] tx_byte_reg;
  sss_tx_state_t tx_state_reg;
  logic ctrl_c;
  logic rd_operation_event_latch;
  logic rd_questionable_event_latch;
  logic rd_std_event;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [8:0] fifo_out_data;
  logic can_load;
  logic mav;

  // Only the second stage is read
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cond_meta_reg <= '0;
      cond_sync_reg <= '0;
    end
    else
    begin
      cond_meta_reg <= cond_pins;
      cond_sync_reg <= cond_meta_reg;
    end
  end

  always_comb
  begin
    operation_condition_live = '0;
    operation_condition_live[OPC_CAL] = cond_sync_reg[0]; // RL11
    operation_condition_live[OPC_SETTLE] = cond_sync_reg[1]; // RL11
    operation_condition_live[OPC_RANGE] = cond_sync_reg[2]; // RL11
    operation_condition_live[OPC_MEAS] = 1'b1; // RL12
    operation_condition_live[OPC_TEST] = cond_sync_reg[3]; // RL12
    operation_condition_live[OPC_PROG] = cond_sync_reg[4]; // RL12
    questionable_condition_live = '0; // RL15
    questionable_condition_live[QC_VOLT] = cond_sync_reg[5]; // RL13
    questionable_condition_live[QC_TIME] = cond_sync_reg[6]; // RL14
    questionable_condition_live[QC_TEMP] = cond_sync_reg[7]; // RL14
    questionable_condition_live[QC_CAL] = cond_sync_reg[8]; // RL15
    questionable_condition_live[QC_PRES] = cond_sync_reg[9]; // RL15
  end

  assign rd_operation_event_latch = acc_rd && (acc_sel == SEL_OPERATION_EVENT_LATCH);
  assign rd_questionable_event_latch = acc_rd && (acc_sel == SEL_QUESTIONABLE_EVENT_LATCH);
  assign rd_std_event = acc_rd && (acc_sel == SEL_STANDARD_EVENT_FLAGS);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      oper_prev_reg <= '0;
      ques_prev_reg <= '0;
    end
    else
    begin
      oper_prev_reg <= operation_condition_live;
      ques_prev_reg <= questionable_condition_live;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      operation_event_latch_reg <= '0;
      questionable_event_latch_reg <= '0;
    end
    else
    begin
      operation_event_latch_reg <= (rd_operation_event_latch ? '0 : operation_event_latch_reg) // RL23
        | (operation_condition_live & ~oper_prev_reg); // RL24
      questionable_event_latch_reg <= (rd_questionable_event_latch ? '0 : questionable_event_latch_reg) // RL23
        | (questionable_condition_live & ~ques_prev_reg) // RL24
        | ({15'h0000, ev_param_ignored} << QC_WARN); // RL16
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      standard_event_flags_reg <= ESR_RESET; // RL6
    end
    else
    begin
      standard_event_flags_reg <= (rd_std_event ? '0 : standard_event_flags_reg)
        | ({7'h00, ev_cmd_error} << ESR_CME) // RL7
        | ({7'h00, ev_exec_error} << ESR_EXE) // RL8
        | ({7'h00, ev_device_error} << ESR_DDE) // RL8
        | ({7'h00, ev_query && !mav} << ESR_QYE) // RL9
        | ({7'h00, ev_opc} << ESR_OPC); // RL10
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      operation_event_mask_reg <= MASK16_RESET;
      questionable_event_mask_reg <= MASK16_RESET;
      standard_event_mask_reg <= MASK8_RESET;
      service_request_mask_reg <= MASK8_RESET;
    end
    else if (acc_wr)
    begin
      unique case (acc_sel)
        SEL_OPERATION_EVENT_MASK: operation_event_mask_reg <= acc_wdata;
        SEL_QUESTIONABLE_EVENT_MASK: questionable_event_mask_reg <= acc_wdata;
        SEL_STANDARD_EVENT_MASK: standard_event_mask_reg <= acc_wdata[7:0];
        SEL_SERVICE_REQUEST_MASK: service_request_mask_reg <= acc_wdata[7:0];
        default: ;
      endcase
    end
  end

  assign mav = fifo_out_valid || tx_valid_reg || (tx_state_reg != TX_DATA); // RL3

  always_comb
  begin
    stb_next = '0; // RL5
    stb_next[STB_OPER] = |(operation_event_latch_reg & operation_event_mask_reg); // RL1
    stb_next[STB_ESB] = |(standard_event_flags_reg & standard_event_mask_reg); // RL2
    stb_next[STB_MAV] = mav; // RL3
    stb_next[STB_QUES] = |(questionable_event_latch_reg & questionable_event_mask_reg); // RL4
    stb_next[STB_QUEUE] = err_queue_nonempty; // RL5
    stb_next[STB_RQS] = |({stb_next[7], 1'b0, stb_next[5:0]} & service_request_mask_reg);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_summary_byte_reg <= '0;
      service_request_reg <= 1'b0;
    end
    else
    begin
      status_summary_byte_reg <= stb_next;
      service_request_reg <= stb_next[STB_RQS];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_rdata_reg <= '0;
      acc_rvalid_reg <= 1'b0;
    end
    else
    begin
      acc_rvalid_reg <= acc_rd;
      if (acc_rd)
      begin
        unique case (acc_sel)
          SEL_STATUS_SUMMARY_BYTE: acc_rdata_reg <= {8'h00, stb_next};
          SEL_SERVICE_REQUEST_MASK: acc_rdata_reg <= {8'h00, service_request_mask_reg};
          SEL_STANDARD_EVENT_FLAGS: acc_rdata_reg <= {8'h00, standard_event_flags_reg};
          SEL_STANDARD_EVENT_MASK: acc_rdata_reg <= {8'h00, standard_event_mask_reg};
          SEL_OPERATION_EVENT_LATCH: acc_rdata_reg <= operation_event_latch_reg; // RL23
          SEL_OPERATION_CONDITION_LIVE: acc_rdata_reg <= operation_condition_live; // RL23
          SEL_OPERATION_EVENT_MASK: acc_rdata_reg <= operation_event_mask_reg;
          SEL_QUESTIONABLE_EVENT_LATCH: acc_rdata_reg <= questionable_event_latch_reg; // RL23
          SEL_QUESTIONABLE_CONDITION_LIVE: acc_rdata_reg <= questionable_condition_live;
          SEL_QUESTIONABLE_EVENT_MASK: acc_rdata_reg <= questionable_event_mask_reg;
          default: acc_rdata_reg <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      emulation_mode_reg <= 1'b0;
    end
    else if (lang_emulation)
    begin
      emulation_mode_reg <= 1'b1; // RL19
    end
    else if (lang_standard)
    begin
      emulation_mode_reg <= 1'b0; // RL19
    end
  end

  assign ctrl_c = rx_valid && (rx_byte == CH_CTRLC) && single_unit;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_valid_reg <= 1'b0;
      cmd_byte_reg <= '0;
      cmd_end_reg <= 1'b0;
      rx_flush_reg <= 1'b0;
      msg_start_reg <= 1'b1;
      cmd_to_standard_reg <= 1'b1;
    end
    else
    begin
      cmd_valid_reg <= 1'b0;
      cmd_end_reg <= 1'b0;
      rx_flush_reg <= 1'b0;
      if (rx_valid)
      begin
        if (rx_byte == CH_CR || rx_byte == CH_LF)
        begin
          cmd_end_reg <= !msg_start_reg; // RL20
          msg_start_reg <= 1'b1;
        end
        else if (ctrl_c)
        begin
          rx_flush_reg <= 1'b1; // RL22
          msg_start_reg <= 1'b1;
        end
        else if (rx_byte != CH_XOFF && rx_byte != CH_XON)
        begin
          cmd_valid_reg <= 1'b1;
          cmd_byte_reg <= rx_byte;
          msg_start_reg <= 1'b0;
          if (msg_start_reg)
          begin
            cmd_to_standard_reg <= !emulation_mode_reg || (rx_byte == CH_COLON); // RL17
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addressing_on_reg <= 1'b1;
    end
    else if (ctrl_c)
    begin
      addressing_on_reg <= 1'b0; // RL22
    end
    else if (addressing_set)
    begin
      addressing_on_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_paused_reg <= 1'b0;
    end
    else if (rx_valid && rx_byte == CH_XOFF)
    begin
      tx_paused_reg <= 1'b1; // RL21
    end
    else if ((rx_valid && rx_byte == CH_XON) || ctrl_c)
    begin
      tx_paused_reg <= 1'b0; // RL21
    end
  end

  // Response bytes queue here; a full queue stalls the command engine
  sss_fifo #(
    .WIDTH(SSS_FIFO_WIDTH),
    .DEPTH(SSS_FIFO_DEPTH)
  ) u_resp_fifo (
    .clk(ref_clk),
    .resetn(resetn),
    .flush(ctrl_c), // RL22
    .in_valid(resp_valid && resp_ready),
    .in_ready(fifo_in_ready),
    .in_data({resp_last, resp_byte}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign can_load = (!tx_valid_reg || tx_ready) && !tx_paused_reg; // RL21
  assign fifo_out_ready = (tx_state_reg == TX_DATA) && can_load;

  // A byte already offered is allowed to finish after XOFF
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_state_reg <= TX_DATA;
      tx_valid_reg <= 1'b0;
      tx_byte_reg <= '0;
    end
    else if (ctrl_c)
    begin
      tx_state_reg <= TX_DATA; // RL22
      tx_valid_reg <= 1'b0;
    end
    else
    begin
      if (tx_valid_reg && tx_ready)
      begin
        tx_valid_reg <= 1'b0;
      end
      if (can_load)
      begin
        unique case (tx_state_reg)
          TX_DATA:
          begin
            if (fifo_out_valid)
            begin
              tx_valid_reg <= 1'b1;
              tx_byte_reg <= fifo_out_data[7:0];
              if (fifo_out_data[8])
              begin
                tx_state_reg <= TX_CR;
              end
            end
          end
          TX_CR:
          begin
            tx_valid_reg <= 1'b1;
            tx_byte_reg <= CH_CR; // RL20
            tx_state_reg <= TX_LF;
          end
          TX_LF:
          begin
            tx_valid_reg <= 1'b1;
            tx_byte_reg <= CH_LF; // RL20
            tx_state_reg <= TX_DATA;
          end
        endcase
      end
    end
  end

  // Emulated panel status: remote flag follows emulation mode, relays always off
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      emul_status_byte0 <= '0;
      relay_strip_output <= '0;
    end
    else
    begin
      emul_status_byte0 <= {7'h00, emulation_mode_reg} << EMUL_REMOTE_BIT; // RL18
      relay_strip_output <= '0; // RL18
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resp_ready <= 1'b0;
    end
    else
    begin
      resp_ready <= fifo_in_ready && !(resp_valid && resp_ready);
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_byte = tx_byte_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_byte = cmd_byte_reg;
  assign cmd_end = cmd_end_reg;
  assign cmd_to_standard = cmd_to_standard_reg;
  assign rx_flush = rx_flush_reg;
  assign addressing_on = addressing_on_reg;
  assign emulation_mode = emulation_mode_reg;
  assign acc_rdata = acc_rdata_reg;
  assign acc_rvalid = acc_rvalid_reg;
  assign status_summary_byte = status_summary_byte_reg;
  assign service_request = service_request_reg;
endmodule

// >>> verification/scpi_status_serial_interface_test.sv
// Self-checking bench for the status and serial-link block.
// Assumes the host model as serial peer.
`timescale 1ns/1ns
module scpi_status_serial_interface_test;
  import sss_pkg::*;
  logic ref_clk, resetn, single_unit, stall, acc_rd, acc_wr, resp_valid, resp_last;
  logic err_queue_nonempty, rx_valid, tx_valid, tx_ready, cmd_valid, cmd_end, rx_flush;
  logic cmd_to_standard, addressing_on, resp_ready, emulation_mode, acc_rvalid, service_request;
  logic [8:0] pv;
  logic [9:0] cond_pins;
  logic [3:0] acc_sel;
  logic [15:0] acc_wdata, acc_rdata;
  logic [7:0] resp_byte, rx_byte, tx_byte, cmd_byte, emul_status_byte0, relay_strip_output;
  logic [7:0] status_summary_byte;
  logic [8:0] cmds[$];
  int err_count, checks, ends, flushes;
  localparam logic [7:0] EB [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
  localparam logic [7:0] TX1 [4] = '{8'h41, 8'h42, CH_CR, CH_LF};

  sss_status_serial dut (.*, .addressing_set(pv[8]), .lang_emulation(pv[6]),
    .lang_standard(pv[7]), .ev_cmd_error(pv[0]), .ev_exec_error(pv[1]),
    .ev_device_error(pv[2]), .ev_query(pv[3]), .ev_opc(pv[4]), .ev_param_ignored(pv[5]));
  sss_host_model host (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (cmd_valid)
      cmds.push_back({cmd_to_standard, cmd_byte});
    if (cmd_end)
      ends++;
    if (rx_flush)
      flushes++;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cb(input logic g, input logic e);
    ck({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic rc(input logic [3:0] s, input logic [15:0] e);
    @(posedge ref_clk);
    acc_rd <= 1'b1;
    acc_sel <= s;
    @(posedge ref_clk);
    acc_rd <= 1'b0;
    @(posedge ref_clk);
    cb(acc_rvalid, 1'b1);
    ck(acc_rdata, e);
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge ref_clk);
    acc_wr <= 1'b1;
    acc_sel <= s;
    acc_wdata <= d;
    @(posedge ref_clk);
    acc_wr <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    pv[i] <= 1'b1;
    @(posedge ref_clk);
    pv <= 9'h000;
  endtask
  task automatic resp(input logic [7:0] b, input logic l);
    int n = 0;
    @(posedge ref_clk);
    resp_valid <= 1'b1;
    resp_byte <= b;
    resp_last <= l;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (!resp_ready && n < 50);
    resp_valid <= 1'b0;
  endtask

  initial
  begin
    #200000;
    err_count++;
    close_out();
  end
  initial
  begin
    {resetn, single_unit, stall, acc_rd, acc_wr, resp_valid, resp_last} = 7'h00;
    {err_queue_nonempty, pv, cond_pins, acc_sel, acc_wdata, resp_byte} = '0;
    cyc(5);
    resetn <= 1'b1;
    cyc(4);
    rc(SEL_STANDARD_EVENT_FLAGS, 16'h0080);
    rc(SEL_STANDARD_EVENT_FLAGS, 16'h0000);
    rc(SEL_OPERATION_CONDITION_LIVE, 16'h0010);
    rc(4'hf, 16'h0000);
    wr(SEL_SERVICE_REQUEST_MASK, 16'h0028);
    rc(SEL_SERVICE_REQUEST_MASK, 16'h0028);
    ck({8'h00, status_summary_byte}, 16'h0000);
    $display("test reset state done");
    wr(SEL_STANDARD_EVENT_MASK, 16'h0020);
    for (int i = 0; i < 5; i++)
    begin
      pulse(i);
      cyc(2);
      cb(status_summary_byte[STB_ESB], i == 0);
      rc(SEL_STANDARD_EVENT_FLAGS, {8'h00, EB[i]});
    end
    cyc(2);
    cb(status_summary_byte[STB_ESB], 1'b0);
    $display("test standard events done");
    wr(SEL_OPERATION_EVENT_MASK, 16'h0001);
    cond_pins[0] <= 1'b1;
    cyc(6);
    cb(status_summary_byte[STB_OPER], 1'b1);
    rc(SEL_OPERATION_CONDITION_LIVE, 16'h0011);
    rc(SEL_OPERATION_EVENT_LATCH, 16'h0011);
    rc(SEL_OPERATION_EVENT_LATCH, 16'h0000);
    cyc(2);
    cb(status_summary_byte[STB_OPER], 1'b0);
    cond_pins[4:0] <= 5'h1f;
    cyc(6);
    rc(SEL_OPERATION_CONDITION_LIVE, 16'h4117);
    $display("test operation status done");
    wr(SEL_QUESTIONABLE_EVENT_MASK, 16'h4000);
    cond_pins[9:5] <= 5'h1f;
    pulse(5);
    cyc(6);
    cb(status_summary_byte[STB_QUES], 1'b1);
    rc(SEL_QUESTIONABLE_CONDITION_LIVE, 16'h018d);
    rc(SEL_QUESTIONABLE_EVENT_LATCH, 16'h418d);
    rc(SEL_QUESTIONABLE_EVENT_LATCH, 16'h0000);
    err_queue_nonempty <= 1'b1;
    cyc(3);
    ck({8'h00, status_summary_byte & 8'h07}, 16'h0004);
    err_queue_nonempty <= 1'b0;
    $display("test questionable status done");
    resp(8'h41, 1'b0);
    resp(8'h42, 1'b1);
    cyc(20);
    for (int i = 0; i < 4; i++)
      ck({8'h00, host.got[i]}, {8'h00, TX1[i]});
    host.got.delete();
    stall <= 1'b1;
    resp(8'h43, 1'b1);
    cyc(6);
    cb(status_summary_byte[STB_MAV], 1'b1);
    host.send(CH_XOFF);
    stall <= 1'b0;
    cyc(20);
    ck(16'(host.got.size()), 16'h0001);
    host.send(CH_XON);
    cyc(20);
    ck({host.got[0], host.got[1]}, 16'h430d);
    ck(16'(host.got.size()), 16'h0003);
    cb(status_summary_byte[STB_MAV], 1'b0);
    $display("test transmit done");
    pulse(6);
    cyc(2);
    ck({6'h00, emulation_mode, emul_status_byte0[2], relay_strip_output}, 16'h0300);
    host.send(8'h41);
    host.send(CH_LF);
    host.send(CH_COLON);
    host.send(CH_CR);
    cyc(3);
    ck({7'h00, cmds[0]}, 16'h0041);
    ck({7'h00, cmds[1]}, 16'h013a);
    ck(16'(ends), 16'h0002);
    pulse(7);
    cyc(2);
    cb(emulation_mode, 1'b0);
    $display("test emulation done");
    single_unit <= 1'b1;
    host.send(CH_CTRLC);
    cyc(2);
    ck({14'h0000, addressing_on, flushes[0]}, 16'h0001);
    ck(16'(cmds.size()), 16'h0002);
    pulse(8);
    cyc(2);
    cb(addressing_on, 1'b1);
    $display("test break byte done");
    close_out();
  end
endmodule

// >>> verification/sss_host_model.sv
// Behavioural serial host on the far side of the link.
// Runs on ref_clk; logs every transmitted byte.
`timescale 1ns/1ns
module sss_host_model
(
  input wire logic ref_clk,
  input wire logic stall,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic [7:0] got[$];
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  assign tx_ready = !stall;
  always @(posedge ref_clk)
    if (tx_valid && tx_ready)
      got.push_back(tx_byte);
  // Idle data inverted so a stale byte never looks fresh
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
endmodule

// >>> verification/sss_status_serial_properties.sv
// Concurrent checks on the status and serial-link block ports.
// Bound to every sss_status_serial instance; one ref_clk domain.
`timescale 1ns/1ns
module sss_status_serial_properties
  import sss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic single_unit,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_end,
  input wire logic rx_flush,
  input wire logic addressing_on,
  input wire logic addressing_set,
  input wire logic emulation_mode,
  input wire logic [7:0] emul_status_byte0,
  input wire logic [7:0] relay_strip_output,
  input wire logic acc_rd,
  input wire logic [3:0] acc_sel,
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic [7:0] status_summary_byte
);
  logic paused_reg;
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      paused_reg <= 1'b0;
    else if (rx_valid && rx_byte == CH_XOFF)
      paused_reg <= 1'b1;
    else if (rx_valid && (rx_byte == CH_XON || (rx_byte == CH_CTRLC && single_unit)))
      paused_reg <= 1'b0;
  end
  AST_STB_LOW_ZERO: assert property (status_summary_byte[1:0] == 2'b00)
    else $error("status byte low bits set");
  AST_ESR_FIXED_ZERO: assert property (acc_rvalid && $past(acc_rd) &&
    $past(acc_sel) == SEL_STANDARD_EVENT_FLAGS |-> (acc_rdata & 16'hff42) == 16'h0000)
    else $error("standard event fixed bits wrong");
  AST_OPER_FIXED: assert property (acc_rvalid && $past(acc_rd) &&
    $past(acc_sel) == SEL_OPERATION_CONDITION_LIVE |-> (acc_rdata & 16'hbeb8) == 16'h0010)
    else $error("operation condition fixed bits wrong");
  AST_QUES_FIXED: assert property (acc_rvalid && $past(acc_rd) &&
    $past(acc_sel) == SEL_QUESTIONABLE_CONDITION_LIVE |-> (acc_rdata & 16'hbe62) == 16'h0000)
    else $error("questionable condition fixed bits wrong");
  AST_READ_ANSWER: assert property (acc_rd |=> acc_rvalid)
    else $error("read not answered");
  AST_FLOW_NOT_FORWARDED: assert property (rx_valid &&
    (rx_byte == CH_XON || rx_byte == CH_XOFF) |=> !cmd_valid && !cmd_end)
    else $error("flow byte forwarded");
  AST_TERM_NOT_DATA: assert property (cmd_valid |-> cmd_byte != CH_CR && cmd_byte != CH_LF)
    else $error("terminator forwarded as data");
  AST_CTRLC_FLUSH: assert property (rx_valid && rx_byte == CH_CTRLC && single_unit &&
    !addressing_set |=> rx_flush ##[0:1] !addressing_on)
    else $error("break byte did not flush");
  AST_TX_PAUSED: assert property (paused_reg && $past(paused_reg) &&
    $past(paused_reg, 2) |-> !(tx_valid && tx_ready))
    else $error("transmit while paused");
  AST_EMUL_STATUS: assert property (emulation_mode && $past(emulation_mode) |->
    emul_status_byte0[EMUL_REMOTE_BIT] && relay_strip_output == 8'h00)
    else $error("emulation status wrong");
  cover property (rx_flush);
  cover property (emulation_mode && cmd_valid);
  cover property (paused_reg && tx_valid);
endmodule

bind sss_status_serial sss_status_serial_properties u_props (.*);
